// >>> hdl/pdd_port.sv
// Port drive selection, switch debounce and reset handling of the expander.
// Operation
// - Push-pull port, flip bit makes pin open-drain.
// - Open-drain port, flip bit makes pin push-pull.
// - Three flip registers, reset zero, top bits absent.
// - Enabled input pins of ports 0, 1 debounced.
// - Output pins bypass debounce entirely.
// - Pin zero of port 0 is time base.
// - No debounce unless time base pin enabled.
// - Shared count register sets qualification time.
// - Count of zero disables all debouncing.
// - Input pin turns both drivers off.
// - Output pin drives low side for zero, high side for one unless open-drain.
// - Held in reset until port supply good.
// - Low reset pin forces all defaults.
// - Pin levels change only with reset high.
// - Debouncer restarts on change, updates when stable.
// - Time base needs nine cycles before operation.
`timescale 1ns/10ps
`include "pdd_cfg.svh"
module pdd_port
(
  input wire logic I_CLK,
  input wire logic I_SRST,
  input wire logic I_RESET_N,
  input wire logic I_PORT_SUPPLY_OK,
  input wire logic I_REG_WR_EN,
  input wire logic I_REG_RD_EN,
  input wire logic [7:0] I_REG_ADDR,
  input wire logic [7:0] I_REG_WDATA,
  output logic [7:0] O_REG_RDATA,
  input wire logic [2:0] I_PORT_DRIVE_TYPE_SELECT,
  input wire logic [`PDD_NPINS-1:0] I_PIN_IS_INPUT,
  input wire logic [`PDD_NPINS-1:0] I_OUTPUT_VALUE,
  input wire logic [`PDD_NPINS-1:0] I_PIN_IN,
  output logic [`PDD_NPINS-1:0] O_PIN_OUT,
  output logic [`PDD_NPINS-1:0] O_PIN_OE,
  output logic [`PDD_NPINS-1:0] O_HIGH_SIDE_DRIVER,
  output logic [`PDD_NPINS-1:0] O_LOW_SIDE_DRIVER,
  output logic [`PDD_NPINS-1:0] O_PIN_LEVEL,
  output logic O_SERIAL_RESET
);
  import pdd_pkg::*;

  pdd_top_st_t st_r;
  pdd_top_st_t st_nxt;
  pdd_deb_if dif ();
  logic dev_rst;
  logic active;
  logic tick;
  logic [`PDD_NPINS-1:0] od;
  logic [`PDD_NPINS-1:0] deb_sel;

  // Per-pin open-drain mask: the port-wide type inverted by each flip bit.
  function automatic logic [`PDD_NPINS-1:0] od_mask
  (
    input logic [2:0] sel,
    input logic [7:0] f0,
    input logic [7:0] f1,
    input logic [7:0] f2
  );
    logic [`PDD_NPINS-1:0] wide;
    wide = {{6{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    od_mask = wide ^ {f2[5:0], f1, f0};
  endfunction : od_mask

  // Settled value of a three-stage sampled level.
  function automatic logic settle(input logic [2:0] s, input logic held);
    settle = (s[1] == s[2]) ? s[2] : held;
  endfunction : settle

  // Internal reset covers the soft reset, the reset pin and the supply.
  // supply gate
  assign dev_rst = I_SRST || !st_r.rn_ok || !st_r.sup_ok;

  assign active = (st_r.dcnt != `PDD_CNT_OFF) && I_PIN_IS_INPUT[0] && st_r.deb0[0];

  assign tick = st_r.lvl[0] && !st_r.tb_prev;

  assign od = od_mask(I_PORT_DRIVE_TYPE_SELECT, st_r.flip0, st_r.flip1, st_r.flip2);

  assign deb_sel = {6'h00, {st_r.deb1, st_r.deb0[7:1]} & I_PIN_IS_INPUT[15:1], 1'b0}
    & {`PDD_NPINS{active}};

  // Debouncer bank hookup; counting only starts after warm-up.
  assign dif.tick = tick && (st_r.fsm == S_RUN);
  assign dif.count = st_r.dcnt;
  assign dif.en = deb_sel[15:1];
  assign dif.raw = st_r.lvl[15:1];

  pdd_debounce u_deb
  (
    .i_clk(I_CLK),
    .i_srst(dev_rst),
    .dif(dif)
  );

  // Next state: sampling, registers, time base and pin drivers.
  always_comb
  begin
    st_nxt = st_r;
    // Pins and reset levels are sampled three times; the first stage
    // feeds only the second, and a change counts once stages two and
    // three agree.
    st_nxt.p1 = I_PIN_IN;
    st_nxt.p2 = st_r.p1;
    st_nxt.p3 = st_r.p2;
    for (int k = 0; k < `PDD_NPINS; k++)
    begin
      st_nxt.lvl[k] = settle({st_r.p3[k], st_r.p2[k], st_r.p1[k]}, st_r.lvl[k]);
    end
    st_nxt.rn = {st_r.rn[1:0], I_RESET_N};
    st_nxt.sup = {st_r.sup[1:0], I_PORT_SUPPLY_OK};
    st_nxt.rn_ok = settle(st_r.rn, st_r.rn_ok);
    st_nxt.sup_ok = settle(st_r.sup, st_r.sup_ok);
    st_nxt.tb_prev = st_r.lvl[0];
    st_nxt.rst = dev_rst;
    if (dev_rst)
    begin
      st_nxt.flip0 = `PDD_RST_BYTE;
      st_nxt.flip1 = `PDD_RST_BYTE;
      st_nxt.flip2 = `PDD_RST_BYTE;
      st_nxt.deb0 = `PDD_RST_BYTE;
      st_nxt.deb1 = `PDD_RST_BYTE;
      st_nxt.dcnt = `PDD_RST_BYTE;
      st_nxt.warm = '0;
      st_nxt.fsm = S_OFF;
      st_nxt.rdata = `PDD_RST_BYTE;
      st_nxt.hs = '0;
      st_nxt.ls = '0;
    end
    else
    begin
      // Register writes; unmapped addresses are ignored.
      if (I_REG_WR_EN)
      begin
        case (I_REG_ADDR)
          `PDD_ADDR_FLIP0: st_nxt.flip0 = I_REG_WDATA;
          `PDD_ADDR_FLIP1: st_nxt.flip1 = I_REG_WDATA;
          `PDD_ADDR_FLIP2: st_nxt.flip2 = I_REG_WDATA & `PDD_FLIP2_MASK;
          `PDD_ADDR_DEB0: st_nxt.deb0 = I_REG_WDATA;
          `PDD_ADDR_DEB1: st_nxt.deb1 = I_REG_WDATA;
          `PDD_ADDR_DCNT: st_nxt.dcnt = I_REG_WDATA;
          default: st_nxt.flip0 = st_r.flip0;
        endcase
      end
      // Reads return the stored byte next cycle, zero when unmapped.
      if (I_REG_RD_EN)
      begin
        case (I_REG_ADDR)
          `PDD_ADDR_FLIP0: st_nxt.rdata = st_r.flip0;
          `PDD_ADDR_FLIP1: st_nxt.rdata = st_r.flip1;
          `PDD_ADDR_FLIP2: st_nxt.rdata = st_r.flip2;
          `PDD_ADDR_DEB0: st_nxt.rdata = st_r.deb0;
          `PDD_ADDR_DEB1: st_nxt.rdata = st_r.deb1;
          `PDD_ADDR_DCNT: st_nxt.rdata = st_r.dcnt;
          default: st_nxt.rdata = `PDD_RST_BYTE;
        endcase
      end
      // Warm-up: the debouncers get ticks only after nine time base edges,
      // so a freshly connected oscillator cannot qualify a switch early.
      case (st_r.fsm)
        S_OFF:
        begin
          st_nxt.warm = '0;
          if (active)
            st_nxt.fsm = S_WARM;
        end
        S_WARM:
        begin
          if (!active)
            st_nxt.fsm = S_OFF;
          else if (tick && st_r.warm == 4'(`PDD_WARM_TICKS - 4'h1))
            st_nxt.fsm = S_RUN;
          else if (tick)
            st_nxt.warm = 4'(st_r.warm + 4'h1);
        end
        S_RUN:
        begin
          if (!active)
            st_nxt.fsm = S_OFF;
        end
        default: st_nxt.fsm = S_OFF;
      endcase
      st_nxt.hs = ~I_PIN_IS_INPUT & ~od & I_OUTPUT_VALUE;
      st_nxt.ls = ~I_PIN_IS_INPUT & ~I_OUTPUT_VALUE;
    end
    if (!dev_rst)
    begin
      st_nxt.pin_lvl = st_r.lvl;
      st_nxt.pin_lvl[15:1] = (deb_sel[15:1] & dif.filt) | (~deb_sel[15:1] & st_r.lvl[15:1]);
    end
  end

  // State register with synchronous reset to constants only.
  always_ff @(posedge I_CLK)
  begin
    if (I_SRST)
    begin
      // Serial reset reads high and the machine sits in a legal state while the
      // soft reset holds, so a host cannot mistake the soft reset for ready.
      st_r <= '0;
      st_r.rst <= 1'b1;
      st_r.fsm <= S_OFF;
    end
    else
      st_r <= st_nxt;
  end

  // Outputs come straight from flip-flops, the pin enable from an OR of two.
  assign O_REG_RDATA = st_r.rdata;
  assign O_HIGH_SIDE_DRIVER = st_r.hs;
  assign O_LOW_SIDE_DRIVER = st_r.ls;
  assign O_PIN_OUT = st_r.hs;
  assign O_PIN_OE = st_r.hs | st_r.ls;
  assign O_PIN_LEVEL = st_r.pin_lvl;
  assign O_SERIAL_RESET = st_r.rst;

  // Nine ticks seen while warming, with the gate still open.
  sequence warm_last_s;
    st_r.fsm == S_WARM && active && tick && st_r.warm == 4'(`PDD_WARM_TICKS - 4'h1);
  endsequence

  sequence run_next_s;
    ##1 st_r.fsm == S_RUN;
  endsequence

  // Push-pull port with a flip bit never drives high.
  od_flip_a: assert property (@(posedge I_CLK) disable iff (dev_rst)
    !I_PORT_DRIVE_TYPE_SELECT[1] && st_r.flip1[1] && !I_PIN_IS_INPUT[9]
    && I_OUTPUT_VALUE[9] |=> !O_HIGH_SIDE_DRIVER[9] && !O_PIN_OE[9])
    else $error("flipped push-pull pin drove high");

  // Open-drain port with a flip bit drives high.
  pp_flip_a: assert property (@(posedge I_CLK) disable iff (dev_rst)
    I_PORT_DRIVE_TYPE_SELECT[1] && st_r.flip1[1] && !I_PIN_IS_INPUT[9]
    && I_OUTPUT_VALUE[9] |=> O_HIGH_SIDE_DRIVER[9] && !O_LOW_SIDE_DRIVER[9])
    else $error("flipped open-drain pin did not drive high");

  // Absent top bits of the third flip register read zero.
  flip_top_a: assert property (@(posedge I_CLK) disable iff (I_SRST)
    I_REG_RD_EN && I_REG_ADDR == `PDD_ADDR_FLIP2 |=> O_REG_RDATA[7:6] == 2'h0)
    else $error("absent flip bits read nonzero");

  // Input pins have both drivers off.
  input_hiz_a: assert property (@(posedge I_CLK) disable iff (I_SRST)
    ##1 (O_PIN_OE & $past(I_PIN_IS_INPUT)) == '0)
    else $error("input pin driven");

  // Output pins drive low for a zero value.
  out_low_a: assert property (@(posedge I_CLK) disable iff (dev_rst)
    !I_PIN_IS_INPUT[9] && !I_OUTPUT_VALUE[9] |=> O_LOW_SIDE_DRIVER[9])
    else $error("output zero not driven low");

  // A zero count keeps the time base machine off.
  cnt_zero_a: assert property (@(posedge I_CLK) disable iff (dev_rst)
    st_r.dcnt == `PDD_CNT_OFF |=> st_r.fsm == S_OFF && !dif.tick)
    else $error("debounce ran with zero count");

  // The ninth tick of warm-up starts normal operation.
  warm_run_a: assert property (@(posedge I_CLK) disable iff (dev_rst)
    warm_last_s |-> run_next_s)
    else $error("warm-up did not end on ninth tick");

  // Reset drops every driver and clears the count register.
  reset_dflt_a: assert property (@(posedge I_CLK) disable iff (I_SRST)
    dev_rst |=> O_PIN_OE == '0 && st_r.dcnt == `PDD_CNT_OFF && O_SERIAL_RESET)
    else $error("reset did not restore defaults");

  // An output pin's level skips the debouncer.
  out_bypass_a: assert property (@(posedge I_CLK) disable iff (dev_rst)
    !I_PIN_IS_INPUT[1] |=> O_PIN_LEVEL[1] == $past(st_r.lvl[1]))
    else $error("output pin level went through debounce");

  // Pin levels stay put while the reset pin or the port supply holds reset; soft reset clears them.
  lvl_frozen_a: assert property (@(posedge I_CLK) disable iff (I_SRST)
    dev_rst |=> $stable(O_PIN_LEVEL))
    else $error("pin level moved during reset");

  // A low port supply keeps the block in reset.
  supply_hold_a: assert property (@(posedge I_CLK) disable iff (I_SRST)
    !st_r.sup_ok |=> O_SERIAL_RESET)
    else $error("reset released with supply low");

  // A push-pull output at one drives the high side only.
  out_high_a: assert property (@(posedge I_CLK) disable iff (dev_rst)
    !I_PIN_IS_INPUT[9] && I_OUTPUT_VALUE[9] && !od[9]
    |=> O_HIGH_SIDE_DRIVER[9] && !O_LOW_SIDE_DRIVER[9])
    else $error("output one not driven high");
endmodule : pdd_port

// >>> hdl/pdd_cfg.svh
// Constants for the pin drive, debounce and reset block.
`ifndef PDD_CFG_SVH
`define PDD_CFG_SVH
`define PDD_NPINS 22
`define PDD_NDEB 15
`define PDD_ADDR_FLIP0 8'h70
`define PDD_ADDR_FLIP1 8'h71
`define PDD_ADDR_FLIP2 8'h72
`define PDD_ADDR_DEB0 8'h74
`define PDD_ADDR_DEB1 8'h75
`define PDD_ADDR_DCNT 8'h76
`define PDD_RST_BYTE 8'h00
`define PDD_FLIP2_MASK 8'h3F
`define PDD_CNT_OFF 8'h00
`define PDD_WARM_TICKS 4'h9
`endif

// >>> hdl/pdd_pkg.sv
// Types shared by the pin drive, debounce and reset block.
`include "pdd_cfg.svh"
package pdd_pkg;
  // Debounce time base states, one-hot.
  typedef enum logic [2:0]
  {
    S_OFF = 3'h1,
    S_WARM = 3'h2,
    S_RUN = 3'h4
  } pdd_fsm_t;

  // Whole state of the top module.
  typedef struct packed {
    logic [`PDD_NPINS-1:0] p1;
    logic [`PDD_NPINS-1:0] p2;
    logic [`PDD_NPINS-1:0] p3;
    logic [`PDD_NPINS-1:0] lvl;
    logic [2:0] rn;
    logic [2:0] sup;
    logic rn_ok;
    logic sup_ok;
    logic tb_prev;
    logic [7:0] flip0;
    logic [7:0] flip1;
    logic [7:0] flip2;
    logic [7:0] deb0;
    logic [7:0] deb1;
    logic [7:0] dcnt;
    logic [3:0] warm;
    pdd_fsm_t fsm;
    logic [`PDD_NPINS-1:0] hs;
    logic [`PDD_NPINS-1:0] ls;
    logic [`PDD_NPINS-1:0] pin_lvl;
    logic [7:0] rdata;
    logic rst;
  } pdd_top_st_t;

  // Whole state of the debouncer bank.
  typedef struct packed {
    logic [`PDD_NDEB-1:0][7:0] cnt;
    logic [`PDD_NDEB-1:0] smp;
    logic [`PDD_NDEB-1:0] out;
  } pdd_deb_st_t;
endpackage : pdd_pkg

// >>> hdl/pdd_deb_if.sv
// Carrier between the port logic and the debouncer bank.
`timescale 1ns/10ps
`include "pdd_cfg.svh"
interface pdd_deb_if;
  logic tick;
  logic [7:0] count;
  logic [`PDD_NDEB-1:0] en;
  logic [`PDD_NDEB-1:0] raw;
  logic [`PDD_NDEB-1:0] filt;
  modport ctl (output tick, output count, output en, output raw, input filt);
  modport deb (input tick, input count, input en, input raw, output filt);
endinterface : pdd_deb_if

// >>> hdl/pdd_debounce.sv
// Bank of independent switch debouncers sharing one tick and one count.
`timescale 1ns/10ps
`include "pdd_cfg.svh"
module pdd_debounce
(
  input wire logic i_clk,
  input wire logic i_srst,
  pdd_deb_if.deb dif
);
  import pdd_pkg::*;

  pdd_deb_st_t st_r;
  pdd_deb_st_t st_nxt;
  logic [`PDD_NDEB-1:0] qual;

  // Each enabled channel restarts on a change and updates only once qualified.
  always_comb
  begin
    st_nxt = st_r;
    qual = '0;
    for (int i = 0; i < `PDD_NDEB; i++)
    begin
      qual[i] = (st_r.cnt[i] == dif.count);
      if (!dif.en[i])
      begin
        // A bypassed channel follows its pin so enabling starts clean.
        st_nxt.cnt[i] = `PDD_CNT_OFF;
        st_nxt.smp[i] = dif.raw[i];
        st_nxt.out[i] = dif.raw[i];
      end
      else if (dif.raw[i] != st_r.smp[i])
      begin
        st_nxt.smp[i] = dif.raw[i];
        st_nxt.cnt[i] = `PDD_CNT_OFF;
      end
      else
      begin
        if (dif.tick && !qual[i])
        begin
          st_nxt.cnt[i] = 8'(st_r.cnt[i] + 8'h01);
        end
        if (qual[i])
        begin
          st_nxt.out[i] = st_r.smp[i];
        end
      end
    end
  end

  // State register.
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign dif.filt = st_r.out;

  // An enabled output moves only after a full stable period.
  deb_qualify_a: assert property (@(posedge i_clk) disable iff (i_srst)
    ((st_r.out ^ $past(st_r.out)) & $past(dif.en & ~qual)) == '0)
    else $error("debounced output changed before qualification");
endmodule : pdd_debounce

// >>> bench/pdd_host_model.sv
// Host model that drives the register port, pin setup and both reset inputs.
`timescale 1ns/10ps
`include "pdd_cfg.svh"
module pdd_host_model
(
  input wire logic i_clk,
  input wire logic [7:0] i_rdata,
  output logic o_reset_n,
  output logic o_supply_ok,
  output logic o_wr_en,
  output logic o_rd_en,
  output logic [7:0] o_addr,
  output logic [7:0] o_wdata,
  output logic [2:0] o_sel,
  output logic [`PDD_NPINS-1:0] o_is_input,
  output logic [`PDD_NPINS-1:0] o_value
);
  // Idle levels at time zero; every pin starts as an input, as after reset.
  initial
  begin
    o_reset_n = 1'b1;
    o_supply_ok = 1'b1;
    o_wr_en = 1'b0;
    o_rd_en = 1'b0;
    o_addr = 8'h00;
    o_wdata = 8'h00;
    o_sel = 3'h0;
    o_is_input = '1;
    o_value = '0;
  end

  // Strobe is held through the taking edge; address is then scrambled on purpose.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk);
    o_addr = a;
    o_wdata = d;
    o_wr_en = 1'b1;
    @(negedge i_clk);
    o_wr_en = 1'b0;
    o_addr = ~a;
    o_wdata = ~d;
  endtask : wr

  // Read data is registered at the taking edge, so it is settled one half cycle later.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge i_clk);
    o_addr = a;
    o_rd_en = 1'b1;
    @(negedge i_clk);
    d = i_rdata;
    o_rd_en = 1'b0;
    o_addr = ~a;
  endtask : rd

  task automatic cfg_out(input logic [2:0] sel, input logic [7:0] fa, input logic [7:0] fd,
    input logic [`PDD_NPINS-1:0] dir, input logic [`PDD_NPINS-1:0] val);
    @(negedge i_clk);
    o_sel = sel;
    wr(fa, fd);
    o_value = val;
    o_is_input = dir;
  endtask : cfg_out

  task automatic set_rst(input logic rn, input logic sup);
    @(negedge i_clk);
    o_reset_n = rn;
    o_supply_ok = sup;
  endtask : set_rst
endmodule : pdd_host_model

// >>> bench/pdd_port_tb.sv
// Self-checking testbench of the pin drive, debounce and reset block.
`timescale 1ns/10ps
`include "pdd_cfg.svh"
module pdd_port_tb;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic tbase = 1'b0;
  logic tb_run = 1'b0;
  logic [`PDD_NPINS-1:1] ext = '0;
  int error_cnt = 0;
  int n_compared = 0;
  logic [7:0] addrs [6] = '{`PDD_ADDR_FLIP0, `PDD_ADDR_FLIP1, `PDD_ADDR_FLIP2,
    `PDD_ADDR_DEB0, `PDD_ADDR_DEB1, `PDD_ADDR_DCNT};
  wire rst_n, sup_ok, wr_en, rd_en, serial_reset;
  wire [7:0] addr, wdata, rdata;
  wire [2:0] sel;
  wire [`PDD_NPINS-1:0] is_in, val, pout, poe, hs, ls, lvl, pad;

  // Pad level: the block wins where it drives, otherwise the outside world.
  assign pad = (poe & pout) | (~poe & {ext, tbase});

  pdd_port uut (.I_CLK(clk), .I_SRST(srst), .I_RESET_N(rst_n), .I_PORT_SUPPLY_OK(sup_ok),
    .I_REG_WR_EN(wr_en), .I_REG_RD_EN(rd_en), .I_REG_ADDR(addr), .I_REG_WDATA(wdata),
    .O_REG_RDATA(rdata), .I_PORT_DRIVE_TYPE_SELECT(sel), .I_PIN_IS_INPUT(is_in),
    .I_OUTPUT_VALUE(val), .I_PIN_IN(pad), .O_PIN_OUT(pout), .O_PIN_OE(poe),
    .O_HIGH_SIDE_DRIVER(hs), .O_LOW_SIDE_DRIVER(ls), .O_PIN_LEVEL(lvl),
    .O_SERIAL_RESET(serial_reset));

  pdd_host_model host (.i_clk(clk), .i_rdata(rdata), .o_reset_n(rst_n), .o_supply_ok(sup_ok),
    .o_wr_en(wr_en), .o_rd_en(rd_en), .o_addr(addr), .o_wdata(wdata), .o_sel(sel),
    .o_is_input(is_in), .o_value(val));

  // Clock of 100 ns period.
  initial
  begin
    forever #50 clk = ~clk;
  end

  // Time base on pin zero, period of eight cycles; it stands still when stopped.
  initial
  begin
    forever
    begin
      repeat (4) @(negedge clk);
      if (tb_run)
        tbase = ~tbase;
    end
  end

  task automatic close_out();
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : close_out

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_compared++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check

  // Bounded wait for a pin level; running out is a mismatch.
  task automatic wait_lvl(input int p, input logic v, input int n);
    int i;
    for (i = 0; i < n && lvl[p] !== v; i++)
      @(negedge clk);
    check(32'(lvl[p]), 32'(v), "debounced level late");
  endtask : wait_lvl

  // Requests only start once internal reset has let go.
  task automatic wait_clear();
    int i;
    for (i = 0; i < 20 && serial_reset !== 1'b0; i++)
      @(negedge clk);
    if (serial_reset !== 1'b0)
    begin
      error_cnt++;
      close_out();
    end
  endtask : wait_clear

  task automatic t_regs();
    logic [7:0] d;
    logic [7:0] w;
    for (int i = 0; i < 6; i++)
    begin
      host.rd(addrs[i], d);
      check(32'(d), 32'(`PDD_RST_BYTE), "reset value");
      w = 8'hC5 ^ 8'(i);
      host.wr(addrs[i], w);
      host.rd(addrs[i], d);
      check(32'(d), 32'(i == 2 ? w & `PDD_FLIP2_MASK : w), "readback");
      host.wr(addrs[i], 8'h00);
    end
    host.wr(8'h73, 8'hFF);
    host.rd(8'h73, d);
    check(32'(d), 32'h0000_0000, "unmapped read");
    $display("test registers done");
  endtask : t_regs

  task automatic t_drive();
    logic od;
    logic hx;
    for (int k = 0; k < 8; k++)
    begin
      host.cfg_out({1'b0, k[2], 1'b0}, `PDD_ADDR_FLIP1, {6'h00, k[1], 1'b0},
        ~(22'h1 << 9), 22'(k[0]) << 9);
      repeat (2) @(negedge clk);
      od = k[2] ^ k[1];
      hx = ~od & k[0];
      check(32'(hs[9]), 32'(hx), "high side");
      check(32'(ls[9]), 32'(!k[0]), "low side");
      check(32'({poe[9], pout[9]}), 32'({hx | ~k[0], hx}), "pad enable");
    end
    host.cfg_out(3'h0, `PDD_ADDR_FLIP1, 8'h00, '1, '1);
    repeat (2) @(negedge clk);
    check(32'(hs | ls | poe), 32'h0000_0000, "input drivers off");
    $display("test drive done");
  endtask : t_drive

  task automatic t_debounce();
    logic lo;
    host.wr(`PDD_ADDR_DCNT, 8'h02);
    host.wr(`PDD_ADDR_DEB0, 8'h03);
    tb_run = 1'b1;
    repeat (100) @(negedge clk);
    ext[1] = 1'b1;
    repeat (6) @(negedge clk);
    check(32'(lvl[1]), 32'h0000_0000, "debounce too early");
    wait_lvl(1, 1'b1, 40);
    ext[1] = 1'b0;
    repeat (3) @(negedge clk);
    ext[1] = 1'b1;
    lo = 1'b0;
    repeat (40)
    begin
      @(negedge clk);
      lo = lo | ~lvl[1];
    end
    check(32'(lo), 32'h0000_0000, "glitch passed");
    tb_run = 1'b0;
    ext[1] = 1'b0;
    repeat (60) @(negedge clk);
    check(32'(lvl[1]), 32'h0000_0001, "counted without time base");
    tb_run = 1'b1;
    wait_lvl(1, 1'b0, 40);
    host.cfg_out(3'h0, `PDD_ADDR_FLIP0, 8'h00, ~22'h2, 22'h2);
    ext[1] = 1'b1;
    repeat (6) @(negedge clk);
    check(32'(lvl[1]), 32'h0000_0001, "output not bypassed");
    host.cfg_out(3'h0, `PDD_ADDR_FLIP0, 8'h00, '1, '0);
    repeat (40) @(negedge clk);
    host.wr(`PDD_ADDR_DEB0, 8'h02);
    ext[1] = 1'b0;
    repeat (6) @(negedge clk);
    check(32'(lvl[1]), 32'h0000_0000, "no time base pin");
    host.wr(`PDD_ADDR_DEB0, 8'h03);
    host.wr(`PDD_ADDR_DCNT, `PDD_CNT_OFF);
    ext[1] = 1'b1;
    repeat (6) @(negedge clk);
    check(32'(lvl[1]), 32'h0000_0001, "zero count");
    tb_run = 1'b0;
    $display("test debounce done");
  endtask : t_debounce

  task automatic t_reset();
    logic [7:0] d;
    logic [`PDD_NPINS-1:0] held;
    for (int k = 0; k < 2; k++)
    begin
      host.cfg_out(3'h0, `PDD_ADDR_FLIP0, 8'h55, ~22'h8, 22'h8);
      repeat (6) @(negedge clk);
      held = lvl;
      host.set_rst(k[0], ~k[0]);
      repeat (8) @(negedge clk);
      check(32'(serial_reset), 32'h0000_0001, "reset not seen");
      check(32'(hs | ls | poe), 32'h0000_0000, "drivers in reset");
      ext = ~ext;
      repeat (6) @(negedge clk);
      check(32'(lvl), 32'(held), "level moved in reset");
      host.set_rst(1'b1, 1'b1);
      wait_clear();
      host.rd(`PDD_ADDR_FLIP0, d);
      check(32'(d), 32'h0000_0000, "register survived reset");
    end
    $display("test reset done");
  endtask : t_reset

  // Watchdog against a hang anywhere in the sequence.
  initial
  begin
    #6_000_000;
    error_cnt++;
    close_out();
  end

  // Main sequence: synchronous reset for eight cycles, then the scenarios.
  initial
  begin
    repeat (8) @(negedge clk);
    srst = 1'b0;
    wait_clear();
    t_regs();
    t_drive();
    t_debounce();
    t_reset();
    close_out();
  end
endmodule : pdd_port_tb
